// *** rtl/wbi_pkg.sv ***
package wbi_pkg;
    // =====================================================
    // timing
    // =====================================================
    localparam int OSC_PER_CPU_STD = 2;
    localparam int OSC_PER_CPU_X2 = 1;
    localparam int CYCLE_CPU_CLKS = 6;
    localparam int STROBE_NORMAL_CLKS = 3;
    localparam int STROBE_STRETCH_CLKS = 15;
    localparam int ALE_CLKS = 1;
    localparam int CNT_W = 5;

    // =====================================================
    // fields
    // =====================================================
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [2:0] {
        WBI_IDLE = 3'b000,
        WBI_ADDR = 3'b001,
        WBI_STRB = 3'b010,
        WBI_HOLD = 3'b011
    } wbi_state_e;

    typedef struct packed {
        logic is_write;
        logic short_addr;
        logic [WORD_W-1:0] addr;
        logic [BYTE_W-1:0] acc_data;
    } wbi_req_s;

    typedef struct packed {
        logic [BYTE_W-1:0] acc_data;
        logic [BYTE_W-1:0] upper_data;
        logic is_write;
    } wbi_rsp_s;
endpackage

// *** rtl/wbi_fifo.sv ***
`timescale 1ns/1ns
module wbi_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } wbi_fifo_s;

    wbi_fifo_s s_q, s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push, pop;

    assign wr_ready_out = s_q.rdy;
    assign rd_valid_out = (s_q.cnt != '0);
    assign rd_data_out = mem_q[s_q.rp];
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // ready registered from the next count so the port comes from a flop
        s_d.rdy = (s_d.cnt != DEPTH[AW:0]);
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
        if (push) begin
            mem_q[s_q.wp] <= wr_data_in;
        end
    end
endmodule

// *** rtl/wbi_bus.sv ***
`timescale 1ns/1ns
// Function
// [R1] wide mode is used only while the wide-bus enable bit is set, else an 8-bit cycle runs.
// [R2] with the enable set every external move, read or write, moves a 16-bit word.
// [R3] the low port carries the low address byte, then the low data byte.
// [R4] the high port carries the high address byte, then the high data byte.
// [R5] a wide write drives the low byte from the accumulator and the high byte from the upper data register.
// [R6] a wide read returns the low byte to the accumulator and captures the high byte in the upper data register.
// [R7] a cycle lasts 6 cpu clocks, 12 oscillator clocks normally or 6 in double-speed mode.
// [R8] the stretch bit widens the read and write strobes from 3 to 15 cpu clocks.
// [R9] a move with an 8-bit indirect address puts the high port register content on the high port.
// [R10] a data-pointer move with page access disable set puts the high port register content on the high port.
// [R11] read and write strobes go to the disk's i/o read and i/o write inputs.
// [R12] the address-latch strobe pulses while the low address is valid on the low port.
// [R13] software loads the upper data register before a wide write.
// [R14] the disk drives read data before the read strobe ends and takes write data during the strobe.
module wbi_bus #(
    parameter int FIFO_DEPTH = wbi_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic wide_bus_enable_in,
    input wire logic strobe_stretch_in,
    input wire logic double_speed_mode_in,
    input wire logic page_access_disable_in,
    input wire logic [7:0] high_port_reg_in,
    input wire logic upper_data_byte_we_in,
    input wire logic [7:0] upper_data_byte_wdata_in,
    input wire wbi_pkg::wbi_req_s req_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    output wbi_pkg::wbi_rsp_s rsp_out,
    output logic rsp_valid_out,
    output logic [7:0] upper_data_byte_reg_out,
    output logic busy_out,
    output logic [7:0] low_port_out,
    output logic low_port_oe_n_out,
    input wire logic [7:0] low_port_in,
    output logic [7:0] high_port_out,
    output logic high_port_oe_n_out,
    input wire logic [7:0] high_port_in,
    output logic ale_out,
    output logic rd_n_out,
    output logic wr_n_out
);
    localparam int REQ_W = $bits(wbi_pkg::wbi_req_s);

    typedef struct packed {
        wbi_pkg::wbi_state_e st;
        logic [wbi_pkg::CNT_W-1:0] cnt;
        logic [wbi_pkg::CNT_W-1:0] strb_len;
        logic ph;
        logic wide;
        wbi_pkg::wbi_req_s req;
        logic [7:0] lo_d;
        logic [7:0] hi_d;
        logic lo_oe_n;
        logic hi_oe_n;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic [7:0] upper;
        wbi_pkg::wbi_rsp_s rsp;
        logic rsp_v;
        logic busy;
    } wbi_bus_s;

    wbi_bus_s s_q, s_d;
    logic [7:0] lo_m_q, lo_s_q, hi_m_q, hi_s_q;
    wbi_pkg::wbi_req_s fifo_data;
    logic fifo_valid, fifo_pop, cpu_tick;

    // =====================================================
    // request queue
    // =====================================================
    wbi_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_data_in(req_in),
        .wr_valid_in(req_valid_in),
        .wr_ready_out(req_ready_out),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop)
    );

    // =====================================================
    // pin synchronisers
    // =====================================================
    always_ff @(posedge ref_clk_in) begin
        lo_m_q <= low_port_in;
        lo_s_q <= lo_m_q;
        hi_m_q <= high_port_in;
        hi_s_q <= hi_m_q;
    end

    // ref clock is the oscillator; cpu tick every 2 or every 1 oscillator clocks [R7]
    assign cpu_tick = double_speed_mode_in || s_q.ph;
    assign fifo_pop = (s_q.st == wbi_pkg::WBI_IDLE) && fifo_valid && cpu_tick;

    // =====================================================
    // sequencer
    // =====================================================
    always_comb begin
        s_d = s_q;
        s_d.rsp_v = 1'b0;
        s_d.ph = double_speed_mode_in ? 1'b0 : ~s_q.ph;
        if (upper_data_byte_we_in) begin
            s_d.upper = upper_data_byte_wdata_in; // [R13]
        end
        if (cpu_tick) begin
            case (s_q.st)
                wbi_pkg::WBI_IDLE: begin
                    if (fifo_valid) begin
                        s_d.req = fifo_data;
                        s_d.wide = wide_bus_enable_in; // [R1] [R2]
                        s_d.strb_len = strobe_stretch_in ? wbi_pkg::CNT_W'(wbi_pkg::STROBE_STRETCH_CLKS)
                                                         : wbi_pkg::CNT_W'(wbi_pkg::STROBE_NORMAL_CLKS); // [R8]
                        s_d.st = wbi_pkg::WBI_ADDR;
                        s_d.cnt = wbi_pkg::CNT_W'(wbi_pkg::ALE_CLKS);
                        s_d.lo_d = fifo_data.addr[7:0]; // [R3]
                        s_d.lo_oe_n = 1'b0;
                        if (fifo_data.short_addr || page_access_disable_in) begin
                            s_d.hi_d = high_port_reg_in; // [R9] [R10]
                        end else begin
                            s_d.hi_d = fifo_data.addr[15:8]; // [R4]
                        end
                        s_d.hi_oe_n = 1'b0;
                        s_d.ale = 1'b1; // [R12]
                    end
                end
                wbi_pkg::WBI_ADDR: begin
                    s_d.ale = 1'b0;
                    s_d.st = wbi_pkg::WBI_STRB;
                    s_d.cnt = s_q.strb_len;
                    if (s_q.req.is_write) begin
                        s_d.wr_n = 1'b0; // [R11]
                        s_d.lo_d = s_q.req.acc_data; // [R5]
                        if (s_q.wide) begin
                            s_d.hi_d = s_q.upper; // [R4] [R5]
                        end
                    end else begin
                        s_d.rd_n = 1'b0; // [R11]
                        s_d.lo_oe_n = 1'b1;
                        // 8-bit reads keep the address byte on the high port, wide reads release it [R1] [R6]
                        s_d.hi_oe_n = s_q.wide;
                    end
                end
                wbi_pkg::WBI_STRB: begin
                    s_d.cnt = s_q.cnt - 1'b1;
                    if (s_q.cnt == wbi_pkg::CNT_W'(1)) begin
                        // sample at strobe end: the disk holds data valid until then [R14]
                        if (!s_q.req.is_write) begin
                            s_d.rsp.acc_data = lo_s_q; // [R3] [R6]
                            if (s_q.wide) begin
                                s_d.upper = hi_s_q; // [R6]
                            end
                        end
                        s_d.rd_n = 1'b1;
                        s_d.wr_n = 1'b1;
                        s_d.st = wbi_pkg::WBI_HOLD;
                        s_d.cnt = wbi_pkg::CNT_W'(wbi_pkg::CYCLE_CPU_CLKS - wbi_pkg::ALE_CLKS
                                                  - wbi_pkg::STROBE_NORMAL_CLKS); // [R7]
                    end
                end
                wbi_pkg::WBI_HOLD: begin
                    s_d.cnt = s_q.cnt - 1'b1;
                    if (s_q.cnt == wbi_pkg::CNT_W'(1)) begin
                        s_d.lo_oe_n = 1'b1;
                        s_d.hi_oe_n = 1'b0;
                        s_d.hi_d = high_port_reg_in;
                        s_d.st = wbi_pkg::WBI_IDLE;
                        s_d.rsp.is_write = s_q.req.is_write;
                        s_d.rsp.upper_data = s_d.upper;
                        s_d.rsp_v = 1'b1;
                    end
                end
                default: begin
                    s_d.st = wbi_pkg::WBI_IDLE;
                end
            endcase
        end
        if (s_d.st == wbi_pkg::WBI_IDLE && s_q.st == wbi_pkg::WBI_IDLE) begin
            s_d.hi_d = high_port_reg_in;
        end
        s_d.busy = (s_d.st != wbi_pkg::WBI_IDLE);
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.lo_oe_n <= 1'b1;
            s_q.rd_n <= 1'b1;
            s_q.wr_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_out = s_q.rsp;
    assign rsp_valid_out = s_q.rsp_v;
    assign upper_data_byte_reg_out = s_q.upper;
    assign busy_out = s_q.busy;
    assign low_port_out = s_q.lo_d;
    assign low_port_oe_n_out = s_q.lo_oe_n;
    assign high_port_out = s_q.hi_d;
    assign high_port_oe_n_out = s_q.hi_oe_n;
    assign ale_out = s_q.ale;
    assign rd_n_out = s_q.rd_n;
    assign wr_n_out = s_q.wr_n;
endmodule

// *** verification/wbi_bus_monitor.sv ***
`timescale 1ns/1ns
module wbi_bus_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic wide_bus_enable_in,
    input wire logic strobe_stretch_in,
    input wire logic double_speed_mode_in,
    input wire logic page_access_disable_in,
    input wire logic [7:0] high_port_reg_in,
    input wire logic rsp_valid_out,
    input wire logic [7:0] upper_data_byte_reg_out,
    input wire logic low_port_oe_n_out,
    input wire logic [7:0] high_port_out,
    input wire logic high_port_oe_n_out,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // =====================================================
    // strobe width counter
    // =====================================================
    logic [5:0] low_q;
    logic [5:0] low_d;
    logic [5:0] exp_len;
    logic strb_n;
    assign strb_n = rd_n_out & wr_n_out;
    assign exp_len = (strobe_stretch_in ? 6'h0F : 6'h03) << !double_speed_mode_in;
    always_comb low_d = strb_n ? 6'h00 : low_q + 6'h01;
    always_ff @(posedge ref_clk_in) low_q <= rst_in ? 6'h00 : low_d;
    // =====================================================
    // checks
    // =====================================================
    AST_STRB_EXCL: assert property (rd_n_out || wr_n_out)
        else $error("both strobes low");
    AST_STRB_LEN: assert property ($rose(strb_n) |-> low_q == exp_len)
        else $error("strobe width off");
    AST_ALE_QUIET: assert property (ale_out |-> strb_n)
        else $error("latch pulse during strobe");
    AST_RD_FLOAT: assert property (!rd_n_out |-> low_port_oe_n_out && (high_port_oe_n_out == wide_bus_enable_in))
        else $error("port driven during read");
    AST_WR_DRIVE: assert property (!wr_n_out |-> !low_port_oe_n_out && !high_port_oe_n_out)
        else $error("port released during write");
    AST_WR_UPPER: assert property (!wr_n_out && wide_bus_enable_in |-> high_port_out == upper_data_byte_reg_out)
        else $error("high byte not from upper register");
    AST_CYCLE_LEN: assert property ($rose(ale_out) && double_speed_mode_in && !strobe_stretch_in
        |-> !rsp_valid_out [*6] ##1 rsp_valid_out)
        else $error("cycle length off");
    AST_RSP_PULSE: assert property (rsp_valid_out |=> !rsp_valid_out)
        else $error("response longer than one cycle");
    AST_PAGE_HIGH: assert property (ale_out && page_access_disable_in |-> high_port_out == high_port_reg_in)
        else $error("page mode high port wrong");
    COV_RD_LONG: cover property ($fell(rd_n_out) && strobe_stretch_in);
    COV_WR: cover property ($fell(wr_n_out) && wide_bus_enable_in);
    COV_PAGE: cover property (ale_out && page_access_disable_in);
endmodule

// *** verification/wbi_disk_model.sv ***
`timescale 1ns/1ns
module wbi_disk_model (
    input wire logic ref_clk_in,
    input wire logic [7:0] low_port_out,
    input wire logic low_port_oe_n_out,
    input wire logic [7:0] high_port_out,
    input wire logic high_port_oe_n_out,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    output logic [7:0] low_port_in,
    output logic [7:0] high_port_in,
    output logic [15:0] addr_out,
    output logic [15:0] wdata_out
);
    // released pins wander so a stale value never matches by luck
    logic [7:0] pat_q = 8'h00;
    always_comb begin
        low_port_in = !low_port_oe_n_out ? low_port_out : (!rd_n_out ? addr_out[7:0] ^ 8'h5A : pat_q);
        high_port_in = !high_port_oe_n_out ? high_port_out : (!rd_n_out ? addr_out[15:8] ^ 8'hC3 : ~pat_q);
    end
    always_ff @(posedge ref_clk_in) begin
        pat_q <= pat_q + 8'h01;
        if (ale_out) addr_out <= {high_port_out, low_port_out};
        if (!wr_n_out) wdata_out <= {high_port_in, low_port_in};
    end
endmodule

// *** verification/wide_external_bus_ide_port_test.sv ***
`timescale 1ns/1ns
module wide_external_bus_ide_port_test;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wide_bus_enable_in = 1'b0, strobe_stretch_in = 1'b0, double_speed_mode_in = 1'b0;
    logic page_access_disable_in = 1'b0, upper_data_byte_we_in = 1'b0, req_valid_in = 1'b0;
    logic [7:0] high_port_reg_in = 8'h00, upper_data_byte_wdata_in = 8'h00;
    wbi_pkg::wbi_req_s req_in = '0;
    wbi_pkg::wbi_rsp_s rsp_out;
    logic req_ready_out, rsp_valid_out, busy_out, low_port_oe_n_out, high_port_oe_n_out, ale_out, rd_n_out, wr_n_out;
    logic [7:0] upper_data_byte_reg_out, low_port_out, low_port_in, high_port_out, high_port_in;
    logic [15:0] m_addr, m_wd;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 11, n, k;
    logic [31:0] r, r2;
    logic [15:0] ea;
    wbi_bus DUT (.ref_clk_in, .rst_in, .wide_bus_enable_in, .strobe_stretch_in, .double_speed_mode_in,
        .page_access_disable_in, .high_port_reg_in, .upper_data_byte_we_in, .upper_data_byte_wdata_in, .req_in,
        .req_valid_in, .req_ready_out, .rsp_out, .rsp_valid_out, .upper_data_byte_reg_out, .busy_out, .low_port_out,
        .low_port_oe_n_out, .low_port_in, .high_port_out, .high_port_oe_n_out, .high_port_in, .ale_out, .rd_n_out,
        .wr_n_out);
    wbi_disk_model DISK (.ref_clk_in, .low_port_out, .low_port_oe_n_out, .high_port_out, .high_port_oe_n_out,
        .ale_out, .rd_n_out, .wr_n_out, .low_port_in, .high_port_in, .addr_out(m_addr), .wdata_out(m_wd));
    // =====================================================
    // helpers
    // =====================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_rsp;
        k = 0;
        do begin
            @(negedge ref_clk_in);
            k++;
        end while (rsp_valid_out !== 1'b1 && k < 100);
        // a response that never comes counts as a mismatch
        chk({7'h00, rsp_valid_out}, 8'h01);
    endtask
    initial forever #50 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    // =====================================================
    // sequence
    // =====================================================
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(negedge ref_clk_in);
        chk({3'h0, low_port_oe_n_out, ale_out, rd_n_out, wr_n_out, busy_out}, 8'h16);
        for (int i = 0; i < 48; i++) begin
            r = $random(seed);
            r2 = $random(seed);
            if (i < 8) r[3:0] = {1'b1, i[2:0]};
            if (i == 0) r[31:16] = 16'hFFFF;
            @(posedge ref_clk_in);
            {wide_bus_enable_in, strobe_stretch_in, double_speed_mode_in, page_access_disable_in} <= r[3:0];
            high_port_reg_in <= r2[15:8];
            upper_data_byte_wdata_in <= r2[7:0];
            upper_data_byte_we_in <= 1'b1;
            @(posedge ref_clk_in);
            upper_data_byte_we_in <= 1'b0;
            @(posedge ref_clk_in);
            req_in <= '{r[4], r[5], r[31:16], r[15:8]};
            req_valid_in <= 1'b1;
            do @(posedge ref_clk_in); while (req_ready_out !== 1'b1);
            req_valid_in <= 1'b0;
            wait_rsp();
            ea = {(r[5] || r[0]) ? r2[15:8] : r[31:24], r[23:16]};
            chk({7'h00, rsp_out.is_write}, {7'h00, r[4]});
            chk({7'h00, busy_out}, 8'h00);
            chk(m_addr[7:0], ea[7:0]);
            chk(m_addr[15:8], ea[15:8]);
            if (r[4]) begin
                chk(m_wd[7:0], r[15:8]);
                if (r[3]) chk(m_wd[15:8], r2[7:0]);
                chk(rsp_out.upper_data, r2[7:0]);
            end else begin
                chk(rsp_out.acc_data, ea[7:0] ^ 8'h5A);
                chk(upper_data_byte_reg_out, r[3] ? ea[15:8] ^ 8'hC3 : r2[7:0]);
                chk(rsp_out.upper_data, r[3] ? ea[15:8] ^ 8'hC3 : r2[7:0]);
            end
        end
        // queue filled to refusal, then drained
        @(posedge ref_clk_in);
        // slow stretched cycles so only one entry drains while the queue fills
        {wide_bus_enable_in, strobe_stretch_in, double_speed_mode_in, page_access_disable_in} <= 4'hC;
        req_in <= '{1'b0, 1'b0, 16'h1234, 8'h00};
        req_valid_in <= 1'b1;
        n = 0;
        do begin
            @(negedge ref_clk_in);
            k = (req_ready_out === 1'b1);
            n += k;
            @(posedge ref_clk_in);
        end while (k == 1 && n < 40);
        req_valid_in <= 1'b0;
        // full queue plus the one entry already taken by the sequencer
        chk(n[7:0], 8'(wbi_pkg::FIFO_DEPTH + 1));
        for (int j = 0; j < n; j++) begin
            wait_rsp();
            chk(upper_data_byte_reg_out, 8'h12 ^ 8'hC3);
            chk(rsp_out.acc_data, 8'h34 ^ 8'h5A);
        end
        tally_and_finish;
    end
endmodule
bind wbi_bus wbi_bus_monitor MON (.ref_clk_in, .rst_in, .wide_bus_enable_in, .strobe_stretch_in,
    .double_speed_mode_in, .page_access_disable_in, .high_port_reg_in, .rsp_valid_out, .upper_data_byte_reg_out,
    .low_port_oe_n_out, .high_port_out, .high_port_oe_n_out, .ale_out, .rd_n_out, .wr_n_out);
